// *** qhb_pkg.sv ***
// qhb_pkg: register indices, field positions and reset values of the
// quad half-bridge control block.
// assumes: a 32-bit classic Wishbone bus, one aligned word per register.

package qhb_pkg;

    // ************************************************************
    // register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [5:0] IDX_SWITCH_CMD  = 6'h01; // bridge_switch_commands
    localparam logic [5:0] IDX_MODE_CTRL   = 6'h02; // bridge_mode_control
    localparam logic [5:0] IDX_SYS_CTRL    = 6'h03; // system_control_reg
    localparam logic [5:0] IDX_INT_FLAG    = 6'h04; // interrupt_flag_reg
    localparam logic [5:0] IDX_SYS_STATUS  = 6'h0C; // system_status_reg

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_SWITCH_CMD  = 8'h00;
    localparam logic [2:0] RST_LIMIT_SEL   = 3'h0;
    localparam logic       RST_BIT         = 1'b0;

    // ************************************************************
    // bridge_mode_control field positions
    // ************************************************************
    localparam int POS_OFFSET_CHOP  = 7;   // offset_chop_enable
    localparam int POS_SENSE_GAIN   = 6;   // sense_gain_select
    localparam int POS_LIMIT_HI     = 2;   // current_limit_select msb
    localparam int POS_LIMIT_LO     = 0;   // current_limit_select lsb

    // ************************************************************
    // system_control_reg field positions
    // ************************************************************
    localparam int POS_POWER_EN     = 7;   // power_stage_enable
    localparam int POS_OT_RESET_EN  = 1;   // high-temperature reset enable

    // ************************************************************
    // interrupt_flag_reg and system_status_reg field positions
    // ************************************************************
    localparam int POS_LOW_VOLT     = 0;   // low_voltage_flag
    localparam int POS_HIGH_VOLT    = 1;   // high_voltage_flag
    localparam int POS_OT_WARN      = 2;   // overtemp_warning_flag
    localparam int POS_BRIDGE_OC    = 0;   // bridge_overcurrent_flag
    localparam int POS_STAT_LV      = 1;   // copy of low_voltage_flag
    localparam int POS_STAT_HV      = 2;   // copy of high_voltage_flag
    localparam int POS_STAT_OT      = 3;   // copy of overtemp_warning_flag

    // ************************************************************
    // current limit selections
    // ************************************************************
    localparam logic [2:0] LIMIT_NONE   = 3'h0; // no limit
    localparam logic [2:0] LIMIT_55MA   = 3'h3; // lowest defined limit

    // ************************************************************
    // synchroniser depth for pin inputs
    // ************************************************************
    localparam int SYNC_STAGES = 3;

endpackage

// *** qhb_bridge_ctrl.sv ***
// qhb_bridge_ctrl: control logic of four half-bridge output stages with
// chopped current limit, offset chopping, shutdown flags and a Wishbone
// register slave.
// assumes: analog comparators and gate monitors arrive as asynchronous
// levels; the gate drivers take the registered drive outputs.

`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - power_stage_enable gates every switch on
// - both commands set: only high side on
// - turn-on waits for opposite gate off
// - reset clears all eight command bits
// - low_side_on_x bits read/write low switches
// - high_side_on_x bits read/write high switches
// - over-limit low side off until chop rise
// - offset chop: bridges 3,4 on falling edge
// - sense_gain_select one: 500 mA; zero: 2.5 A
// - recirculation_detect high while any freewheeling
// - overtemperature reset kills outputs; warning flag
// - overcurrent shuts its side; sets flag
// - write one clears overcurrent, re-enables outputs
// - voltage flag set forces all outputs off
// - voltage flags write-one-clear, set again persisting
// - three limit bits select current, reset clears
// - offset_chop_enable read/write, reset clears
// - sense_gain_select read/write, reset clears
// - power_stage_enable read/write, reset clears
// - writing zero leaves overcurrent state alone
module qhb_bridge_ctrl #(
    parameter int ADR_WIDTH = 8   // wishbone byte address width
) (
    // clock and reset
    input  wire  logic                 i_mclk,
    input  wire  logic                 i_reset_n,
    // wishbone slave
    input  wire  logic                 i_wb_cyc,
    input  wire  logic                 i_wb_stb,
    input  wire  logic                 i_wb_we,
    input  wire  logic [ADR_WIDTH-1:0] i_wb_adr,
    input  wire  logic [3:0]           i_wb_sel,
    input  wire  logic [31:0]          i_wb_dat,
    output logic       [31:0]          o_wb_dat,
    output logic                       o_wb_ack,
    // chop clock and analog sense levels (asynchronous)
    input  wire  logic                 i_chop_clock_in,
    input  wire  logic [3:0]           i_low_over_limit,
    input  wire  logic                 i_high_overcurrent,
    input  wire  logic                 i_low_overcurrent,
    input  wire  logic                 i_low_voltage,
    input  wire  logic                 i_high_voltage,
    input  wire  logic                 i_overtemp_warning,
    input  wire  logic                 i_overtemp_limit,
    input  wire  logic [3:0]           i_recirc_sense,
    // gate-off confirmation from the drivers (asynchronous)
    input  wire  logic [3:0]           i_high_gate_off,
    input  wire  logic [3:0]           i_low_gate_off,
    // switch drives to bridge_outputs
    output logic       [3:0]           o_high_side_drive,
    output logic       [3:0]           o_low_side_drive,
    // analog setup and status
    output logic       [2:0]           o_current_limit_select,
    output logic                       o_sense_gain_select,
    output logic                       o_recirculation_detect,
    output logic                       o_overtemp_reset
);

    // ************************************************************
    // elaboration check
    // ************************************************************
    if (ADR_WIDTH < 8) begin : g_adr_check
        $error("qhb_bridge_ctrl: ADR_WIDTH must be at least 8");
    end

    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam int NSYNC = 23;

    logic [NSYNC-1:0] raw_in;      // all asynchronous inputs
    logic [NSYNC-1:0] sync_a;      // first stage, read only by sync_b
    logic [NSYNC-1:0] sync_b;      // second stage
    logic [NSYNC-1:0] sync_c;      // third stage
    logic [NSYNC-1:0] filt;        // accepted level

    assign raw_in = {i_chop_clock_in, i_low_over_limit, i_high_overcurrent,
                     i_low_overcurrent, i_low_voltage, i_high_voltage,
                     i_overtemp_warning, i_overtemp_limit, i_recirc_sense,
                     i_high_gate_off, i_low_gate_off};

    // three flip-flops; a change counts once stages two and three agree
    genvar gs;
    for (gs = 0; gs < NSYNC; gs = gs + 1) begin : g_sync
        always_ff @(posedge i_mclk) begin
            if (!i_reset_n) begin
                sync_a[gs] <= 1'b0;
                sync_b[gs] <= 1'b0;
                sync_c[gs] <= 1'b0;
                filt[gs]   <= 1'b0;
            end else begin
                sync_a[gs] <= raw_in[gs];
                sync_b[gs] <= sync_a[gs];
                sync_c[gs] <= sync_b[gs];
                if (sync_b[gs] == sync_c[gs]) begin
                    filt[gs] <= sync_c[gs];
                end
            end
        end
    end

    // named views of the accepted levels
    logic       chop_lvl;          // chop clock level
    logic [3:0] over_limit;        // low side above selected limit
    logic       hs_oc;             // high-side overcurrent
    logic       ls_oc;             // low-side overcurrent
    logic       lv_cond;           // undervoltage
    logic       hv_cond;           // overvoltage
    logic       ot_warn;           // temperature prewarning
    logic       ot_limit;          // temperature shutdown threshold
    logic [3:0] recirc;            // freewheeling current per bridge
    logic [3:0] hg_off;            // high gate confirmed off
    logic [3:0] lg_off;            // low gate confirmed off

    assign chop_lvl   = filt[22];
    assign over_limit = filt[21:18];
    assign hs_oc      = filt[17];
    assign ls_oc      = filt[16];
    assign lv_cond    = filt[15];
    assign hv_cond    = filt[14];
    assign ot_warn    = filt[13];
    assign ot_limit   = filt[12];
    assign recirc     = filt[11:8];
    assign hg_off     = filt[7:4];
    assign lg_off     = filt[3:0];

    // ************************************************************
    // wishbone decode
    // ************************************************************
    logic       req;               // new request this cycle
    logic       wr;                // write strobe on low byte lane
    logic [5:0] idx;               // register index

    assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign wr  = req & i_wb_we & i_wb_sel[0];
    assign idx = i_wb_adr[7:2];

    logic wr_cmd;                  // write to bridge_switch_commands
    logic wr_mode;                 // write to bridge_mode_control
    logic wr_sys;                  // write to system_control_reg
    logic wr_int;                  // write to interrupt_flag_reg
    logic wr_stat;                 // write to system_status_reg

    assign wr_cmd  = wr & (idx == qhb_pkg::IDX_SWITCH_CMD);
    assign wr_mode = wr & (idx == qhb_pkg::IDX_MODE_CTRL);
    assign wr_sys  = wr & (idx == qhb_pkg::IDX_SYS_CTRL);
    assign wr_int  = wr & (idx == qhb_pkg::IDX_INT_FLAG);
    assign wr_stat = wr & (idx == qhb_pkg::IDX_SYS_STATUS);

    // ************************************************************
    // register state
    // ************************************************************
    logic [7:0] switch_cmd;        // bridge_switch_commands
    logic       offset_chop_en;    // offset_chop_enable
    logic       sense_gain;        // sense_gain_select
    logic [2:0] limit_sel;         // current_limit_select
    logic       power_en;          // power_stage_enable
    logic       ot_reset_en;       // high-temperature reset enable
    logic       lv_flag;           // low_voltage_flag
    logic       hv_flag;           // high_voltage_flag
    logic       ot_flag;           // overtemp_warning_flag
    logic       hs_trip;           // high sides shut by overcurrent
    logic       ls_trip;           // low sides shut by overcurrent
    logic       ot_trip;           // overtemperature reset in force

    // overtemperature reset: enabled and threshold reached
    // temperature reset trigger
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            ot_trip <= 1'b0;
        end else begin
            ot_trip <= ot_reset_en & ot_limit;
        end
    end

    // switch commands, bit 7 is bridge 4 high, bit 0 bridge 1 low
    // reset clears commands
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || ot_trip) begin
            switch_cmd <= qhb_pkg::RST_SWITCH_CMD;
        end else if (wr_cmd) begin
            switch_cmd <= i_wb_dat[7:0];
        end
    end

    // mode control fields
    // mode register fields
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || ot_trip) begin
            offset_chop_en <= qhb_pkg::RST_BIT;
            sense_gain     <= qhb_pkg::RST_BIT;
            limit_sel      <= qhb_pkg::RST_LIMIT_SEL;
        end else if (wr_mode) begin
            offset_chop_en <= i_wb_dat[qhb_pkg::POS_OFFSET_CHOP];
            sense_gain     <= i_wb_dat[qhb_pkg::POS_SENSE_GAIN];
            limit_sel      <= i_wb_dat[qhb_pkg::POS_LIMIT_HI:
                                       qhb_pkg::POS_LIMIT_LO];
        end
    end

    // system control bits
    // power enable storage
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || ot_trip) begin
            power_en    <= qhb_pkg::RST_BIT;
            ot_reset_en <= qhb_pkg::RST_BIT;
        end else if (wr_sys) begin
            power_en    <= i_wb_dat[qhb_pkg::POS_POWER_EN];
            ot_reset_en <= i_wb_dat[qhb_pkg::POS_OT_RESET_EN];
        end
    end

    // voltage and temperature flags: set wins over write-one clear
    // sticky voltage flags
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            lv_flag <= 1'b0;
            hv_flag <= 1'b0;
            ot_flag <= 1'b0;
        end else begin
            lv_flag <= lv_cond |
                (lv_flag & ~(wr_int & i_wb_dat[qhb_pkg::POS_LOW_VOLT]));
            hv_flag <= hv_cond |
                (hv_flag & ~(wr_int & i_wb_dat[qhb_pkg::POS_HIGH_VOLT]));
            ot_flag <= ot_warn |
                (ot_flag & ~(wr_int & i_wb_dat[qhb_pkg::POS_OT_WARN]));
        end
    end

    // overcurrent trips; a write of one clears both sides
    logic oc_clear;                // write one to the overcurrent flag

    assign oc_clear = wr_stat & i_wb_dat[qhb_pkg::POS_BRIDGE_OC];

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            hs_trip <= 1'b0;
            ls_trip <= 1'b0;
        end else begin
            hs_trip <= hs_oc | (hs_trip & ~oc_clear);
            ls_trip <= ls_oc | (ls_trip & ~oc_clear);
        end
    end

    // ************************************************************
    // chopped current limit
    // ************************************************************
    logic       chop_prev;         // chop level one cycle ago
    logic       chop_rise;         // rising edge of chop clock
    logic       chop_fall;         // falling edge of chop clock
    logic       limit_on;          // a defined limit is selected
    logic [3:0] chop_off;          // low side held off by the limit
    logic [3:0] rearm;             // re-enable edge per bridge

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            chop_prev <= 1'b0;
        end else begin
            chop_prev <= chop_lvl;
        end
    end

    assign chop_rise = chop_lvl & ~chop_prev;
    assign chop_fall = ~chop_lvl & chop_prev;
    // codes below the lowest limit count as no limit
    assign limit_on  = (limit_sel >= qhb_pkg::LIMIT_55MA);

    assign rearm[0] = chop_rise;
    assign rearm[1] = chop_rise;
    assign rearm[2] = offset_chop_en ? chop_fall : chop_rise;
    assign rearm[3] = offset_chop_en ? chop_fall : chop_rise;

    // per bridge: over limit switches off, chop edge switches back on;
    // a fresh over-limit beats the re-enable edge
    genvar gc;
    for (gc = 0; gc < 4; gc = gc + 1) begin : g_chop
        always_ff @(posedge i_mclk) begin
            if (!i_reset_n) begin
                chop_off[gc] <= 1'b0;
            end else if (limit_on && over_limit[gc]) begin
                chop_off[gc] <= 1'b1;
            end else if (!limit_on || rearm[gc]) begin
                chop_off[gc] <= 1'b0;
            end
        end
    end

    // ************************************************************
    // switch drive with interlock
    // ************************************************************
    logic       global_ok;         // nothing forces all outputs off
    logic [3:0] want_high;         // high side requested
    logic [3:0] want_low;          // low side requested

    assign global_ok = power_en & ~lv_flag & ~hv_flag & ~ot_trip;

    genvar gb;
    for (gb = 0; gb < 4; gb = gb + 1) begin : g_bridge
        assign want_high[gb] = global_ok & switch_cmd[2*gb+1] & ~hs_trip;
        assign want_low[gb]  = global_ok & switch_cmd[2*gb] &
                               ~switch_cmd[2*gb+1] & ~ls_trip &
                               ~chop_off[gb];

        // turn-on only once the opposite gate is confirmed off
        // break before make
        always_ff @(posedge i_mclk) begin
            if (!i_reset_n) begin
                o_high_side_drive[gb] <= 1'b0;
                o_low_side_drive[gb]  <= 1'b0;
            end else begin
                o_high_side_drive[gb] <= want_high[gb] & lg_off[gb] &
                    ~o_low_side_drive[gb];
                o_low_side_drive[gb]  <= want_low[gb] & hg_off[gb] &
                    ~o_high_side_drive[gb];
            end
        end
    end

    // ************************************************************
    // analog setup and status outputs
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_current_limit_select <= qhb_pkg::RST_LIMIT_SEL;
            o_sense_gain_select    <= qhb_pkg::RST_BIT;
            o_recirculation_detect <= 1'b0;
            o_overtemp_reset       <= 1'b0;
        end else begin
            o_current_limit_select <= limit_sel;
            o_sense_gain_select    <= sense_gain;
            o_recirculation_detect <= |recirc;
            o_overtemp_reset       <= ot_trip;
        end
    end

    // ************************************************************
    // wishbone read data and acknowledge
    // ************************************************************
    logic [7:0] rd_byte;           // selected register value

    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            qhb_pkg::IDX_SWITCH_CMD: begin
                rd_byte = switch_cmd;
            end
            qhb_pkg::IDX_MODE_CTRL: begin
                rd_byte = {offset_chop_en, sense_gain, 3'h0, limit_sel};
            end
            qhb_pkg::IDX_SYS_CTRL: begin
                rd_byte[qhb_pkg::POS_POWER_EN]    = power_en;
                rd_byte[qhb_pkg::POS_OT_RESET_EN] = ot_reset_en;
            end
            qhb_pkg::IDX_INT_FLAG: begin
                rd_byte[qhb_pkg::POS_LOW_VOLT]  = lv_flag;
                rd_byte[qhb_pkg::POS_HIGH_VOLT] = hv_flag;
                rd_byte[qhb_pkg::POS_OT_WARN]   = ot_flag;
            end
            qhb_pkg::IDX_SYS_STATUS: begin
                rd_byte[qhb_pkg::POS_BRIDGE_OC] = hs_trip | ls_trip;
                rd_byte[qhb_pkg::POS_STAT_LV]   = lv_flag;
                rd_byte[qhb_pkg::POS_STAT_HV]   = hv_flag;
                rd_byte[qhb_pkg::POS_STAT_OT]   = ot_flag;
            end
            default: begin
                // unmapped index reads zero
                rd_byte = 8'h00;
            end
        endcase
    end

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h00000000;
        end else begin
            o_wb_ack <= req;
            if (req) begin
                o_wb_dat <= {24'h000000, rd_byte};
            end
        end
    end

endmodule

`default_nettype wire

// *** qhb_chk.sv ***
// qhb_chk: port-level checks of the quad half-bridge control block.
// assumes: bound to qhb_bridge_ctrl; pin effects settle within 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module qhb_chk (
    input wire logic       i_mclk,
    input wire logic       i_reset_n,
    input wire logic [3:0] i_low_over_limit,
    input wire logic       i_high_overcurrent,
    input wire logic       i_low_voltage,
    input wire logic       i_high_voltage,
    input wire logic [3:0] i_recirc_sense,
    input wire logic [3:0] o_high_side_drive,
    input wire logic [3:0] o_low_side_drive,
    input wire logic [2:0] o_current_limit_select,
    input wire logic       o_recirculation_detect,
    input wire logic       o_overtemp_reset
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    reset_off_a: assert property ($rose(i_reset_n) |->
        (o_high_side_drive | o_low_side_drive) == 4'h0) else $error("drive after reset");
    one_side_a: assert property (
        (o_high_side_drive & o_low_side_drive) == 4'h0) else $error("both sides on");
    break_make_a: assert property (
        (o_high_side_drive & $past(o_low_side_drive)) == 4'h0
        && (o_low_side_drive & $past(o_high_side_drive)) == 4'h0) else $error("no dead time");
    high_trip_a: assert property (i_high_overcurrent [*8] |->
        o_high_side_drive == 4'h0) else $error("high side on in trip");
    volt_off_a: assert property ((i_low_voltage || i_high_voltage) [*8] |->
        (o_high_side_drive | o_low_side_drive) == 4'h0) else $error("on in voltage fault");
    chop_off_a: assert property (
        (i_low_over_limit[0] && o_current_limit_select >= 3'h3) [*8]
        |-> !o_low_side_drive[0]) else $error("low side not chopped");
    recirc_on_a: assert property ((|i_recirc_sense) [*8] |->
        o_recirculation_detect) else $error("recirculation missed");
    recirc_off_a: assert property ((i_recirc_sense == 4'h0) [*8] |->
        !o_recirculation_detect) else $error("false recirculation");
    ot_off_a: assert property (o_overtemp_reset |->
        (o_high_side_drive | o_low_side_drive) == 4'h0) else $error("on in thermal reset");
    cover property (o_overtemp_reset);
    cover property (o_recirculation_detect);
    cover property (i_low_over_limit[0] && o_current_limit_select == 3'h3);
endmodule
bind qhb_bridge_ctrl qhb_chk u_chk (.i_mclk, .i_reset_n, .i_low_over_limit,
    .i_high_overcurrent, .i_low_voltage, .i_high_voltage, .i_recirc_sense,
    .o_high_side_drive, .o_low_side_drive, .o_current_limit_select,
    .o_recirculation_detect, .o_overtemp_reset);
`default_nettype wire

// *** qhb_load_model.sv ***
// qhb_load_model: gate drivers and windings behind the four bridges.
// assumes: gates confirm off one cycle after the drive drops.
`timescale 1ns/1ps
`default_nettype none
module qhb_load_model (
    input  wire logic       i_mclk,
    input  wire logic       i_reset_n,
    input  wire logic [3:0] i_high_side_drive,
    input  wire logic [3:0] i_low_side_drive,
    output var  logic [3:0] o_high_gate_off,
    output var  logic [3:0] o_low_gate_off,
    output var  logic [3:0] o_recirc_sense
);
    logic [3:0] decay;  // freewheel cycles left
    logic [3:0] was_on; // bridges last carrying current
    // gate charge drains one cycle after the drive drops
    always_ff @(posedge i_mclk) begin
        o_high_gate_off <= ~i_high_side_drive;
        o_low_gate_off  <= ~i_low_side_drive;
    end
    // winding current freewheels for a while after turn-off
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            decay <= 4'h0;
            was_on <= 4'h0;
            o_recirc_sense <= 4'h0;
        end else if (|(i_high_side_drive | i_low_side_drive)) begin
            decay <= 4'hF;
            was_on <= i_high_side_drive | i_low_side_drive;
            o_recirc_sense <= 4'h0;
        end else begin
            decay <= (decay != 4'h0) ? decay - 4'h1 : 4'h0;
            o_recirc_sense <= (decay != 4'h0) ? was_on : 4'h0;
        end
    end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// tb_top: register-level tests of the quad half-bridge control block.
// assumes: Wishbone slave acks one cycle after taking a request.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, chop = 0, hoc = 0;
    logic loc = 0, lv = 0, hv = 0, otw = 0, otl = 0, sg, ack, rec, otr;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0, lim = 4'h0, hd, ld, hgo, lgo, rs, e;
    logic [31:0] wdat = 32'h0, rdat, dout;
    logic [2:0]  cls;
    int mismatches = 0, n_checks = 0;
    qhb_bridge_ctrl dut (.i_mclk(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
        .i_wb_dat(wdat), .o_wb_dat(dout), .o_wb_ack(ack), .i_chop_clock_in(chop),
        .i_low_over_limit(lim), .i_high_overcurrent(hoc), .i_low_overcurrent(loc),
        .i_low_voltage(lv), .i_high_voltage(hv), .i_overtemp_warning(otw),
        .i_overtemp_limit(otl), .i_recirc_sense(rs), .i_high_gate_off(hgo),
        .i_low_gate_off(lgo), .o_high_side_drive(hd), .o_low_side_drive(ld),
        .o_current_limit_select(cls), .o_sense_gain_select(sg),
        .o_recirculation_detect(rec), .o_overtemp_reset(otr));
    qhb_load_model load (.i_mclk(clk), .i_reset_n(rst_n), .i_high_side_drive(hd),
        .i_low_side_drive(ld), .o_high_gate_off(hgo), .o_low_gate_off(lgo),
        .o_recirc_sense(rs));
    initial begin
        forever #4 clk = ~clk;
    end
    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        rdat = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] idx, input logic [7:0] x, input string nm);
        wb(1'b0, idx, 8'h00);
        `CHK(nm, x, rdat[7:0])
    endtask
    task automatic w8();
        repeat (12) @(posedge clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        w8();
        rd(6'h01, 8'h00, "cmd");
        rd(6'h02, 8'h00, "mode");
        rd(6'h03, 8'h00, "system_control_reg");
        rd(6'h3F, 8'h00, "unmapped");
        wb(1'b1, 6'h02, 8'hFF);
        rd(6'h02, 8'hC7, "mode");
        `CHK("gain", 1'b1, sg)
        `CHK("limit", 3'h7, cls)
        wb(1'b1, 6'h02, 8'h00);
        rd(6'h02, 8'h00, "mode");
        `CHK("gain", 1'b0, sg)
        wb(1'b1, 6'h01, 8'h01);
        w8();
        `CHK("low", 4'h0, ld)
        wb(1'b1, 6'h03, 8'h80);
        for (int k = 0; k < 8; k++) begin
            wb(1'b1, 6'h01, 8'h01 << k);
            w8();
            e = 4'h1 << (k / 2);
            `CHK("high", k[0] ? e : 4'h0, hd)
            `CHK("low", k[0] ? 4'h0 : e, ld)
        end
        wb(1'b1, 6'h01, 8'hFF);
        w8();
        `CHK("both", 8'hF0, {hd, ld})
        hoc <= 1'b1;
        w8();
        hoc <= 1'b0;
        w8();
        `CHK("high", 4'h0, hd)
        rd(6'h0C, 8'h01, "ocflag");
        wb(1'b1, 6'h0C, 8'h00);
        w8();
        `CHK("high", 4'h0, hd)
        wb(1'b1, 6'h0C, 8'h01);
        w8();
        `CHK("high", 4'hF, hd)
        wb(1'b1, 6'h01, 8'h55);
        loc <= 1'b1;
        w8();
        loc <= 1'b0;
        w8();
        `CHK("low", 4'h0, ld)
        wb(1'b1, 6'h0C, 8'h01);
        lv <= 1'b1;
        w8();
        `CHK("low", 4'h0, ld)
        wb(1'b1, 6'h04, 8'h01);
        rd(6'h04, 8'h01, "vflag");
        lv <= 1'b0;
        hv <= 1'b1;
        w8();
        hv <= 1'b0;
        w8();
        rd(6'h04, 8'h03, "vflag");
        wb(1'b1, 6'h04, 8'h03);
        w8();
        `CHK("low", 4'hF, ld)
        wb(1'b1, 6'h02, 8'h83);
        wb(1'b1, 6'h01, 8'h41);
        lim <= 4'h9;
        w8();
        lim <= 4'h0;
        w8();
        `CHK("low", 4'h0, ld)
        repeat (3200) @(posedge clk); // 19.5 kHz chop
        chop <= 1'b1;
        w8();
        `CHK("low", 4'h1, ld)
        repeat (3200) @(posedge clk);
        chop <= 1'b0;
        w8();
        `CHK("low", 4'h9, ld)
        wb(1'b1, 6'h01, 8'h00);
        repeat (10) @(posedge clk);
        `CHK("recirc", 1'b1, rec)
        repeat (24) @(posedge clk);
        `CHK("recirc", 1'b0, rec)
        wb(1'b1, 6'h03, 8'h82);
        wb(1'b1, 6'h01, 8'h55);
        w8();
        otl <= 1'b1;
        otw <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK("otreset", 1'b1, otr)
        `CHK("low", 4'h0, ld)
        otl <= 1'b0;
        otw <= 1'b0;
        w8();
        rd(6'h01, 8'h00, "cmd");
        rd(6'h04, 8'h04, "otflag");
        report_and_stop();
    end
endmodule
`default_nettype wire
